/* core/pwmas_core.sv */
// Auto-shutdown, restart, period timer and AXI4-Lite registers
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module pwmas_core #(
	parameter bit REDUCED_PINS = 1'b0
) (
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	// AXI4-Lite write address and data
	input  wire logic                   s_axi_awvalid_in,
	output logic                        s_axi_awready_out,
	input  wire logic [4:0]             s_axi_awaddr_in,
	input  wire logic                   s_axi_wvalid_in,
	output logic                        s_axi_wready_out,
	input  wire logic [31:0]            s_axi_wdata_in,
	input  wire logic [3:0]             s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic                        s_axi_bvalid_out,
	input  wire logic                   s_axi_bready_in,
	output logic [1:0]                  s_axi_bresp_out,
	// AXI4-Lite read
	input  wire logic                   s_axi_arvalid_in,
	output logic                        s_axi_arready_out,
	input  wire logic [4:0]             s_axi_araddr_in,
	output logic                        s_axi_rvalid_out,
	input  wire logic                   s_axi_rready_in,
	output logic [31:0]                 s_axi_rdata_out,
	output logic [1:0]                  s_axi_rresp_out,
	// Fault sources
	input  wire logic                   fault_input_pin_b_in,
	input  wire logic                   comp1_in,
	input  wire logic                   comp2_in,
	// Power management
	input  wire logic                   sleep_in,
	input  wire logic                   pm_clock_select_in,
	input  wire logic                   pm_tick_in,
	// Modulated signals from the PWM generator, order A B C D
	input  wire logic [3:0]             pwm_in,
	// Output pins A B C D
	output pwmas_pkg::pwmas_pin_type    output_a_out,
	output pwmas_pkg::pwmas_pin_type    output_b_out,
	output pwmas_pkg::pwmas_pin_type    output_c_out,
	output pwmas_pkg::pwmas_pin_type    output_d_out,
	// Period begin indication
	output logic                        period_timer_flag_out
);

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic                     shutdown_status;
		logic [2:0]               shutdown_source_select;
		logic [1:0]               pair_ac_shutdown_state;
		logic [1:0]               pair_bd_shutdown_state;
		logic                     auto_restart_enable;
		logic [1:0]               polarity_select;
		logic [7:0]               period_register;
		logic [7:0]               timer_count;
		logic                     period_timer_run;
		logic                     period_timer_flag;
		logic                     period_shutdown;
		pwmas_pkg::pwmas_src_type src_meta;
		pwmas_pkg::pwmas_src_type src_sync;
		pwmas_pkg::pwmas_pin_type [3:0] pins;
		logic                     aw_hold;
		logic [4:0]               aw_addr;
		logic                     w_hold;
		logic [7:0]               w_data;
		logic                     w_lane0;
		logic                     awready;
		logic                     wready;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     arready;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
	} pwmas_state_type;

	pwmas_state_type          st;
	pwmas_state_type          next_st;
	pwmas_pkg::pwmas_src_type src_raw;
	logic [2:0]               sel_raw;
	logic [2:0]               sel_sync;
	logic                     cause_raw;
	logic                     cause_sync;
	logic                     do_write;
	logic                     do_read;
	logic                     tick;
	logic                     period_begin;
	logic                     hold_shutdown;
	logic [7:0]               reg_shutdown;
	logic [3:0]               pin_state [4];

	//------------------------------------------------------------
	// Fault cause decode
	//------------------------------------------------------------
	// Raw sources and decoded select masks
	// RQ21: low pin faults
	assign src_raw = '{fault_pin: ~fault_input_pin_b_in, comp2: comp2_in, comp1: comp1_in};
	// RQ2: source select decode
	assign sel_raw    = st.shutdown_source_select & src_raw;
	assign sel_sync   = st.shutdown_source_select & st.src_sync;
	// RQ19: raw cause for override
	assign cause_raw  = |sel_raw;
	// RQ22: synchronised status cause
	assign cause_sync = |sel_sync;

	// Bus handshakes that commit an access this cycle
	assign do_write = st.aw_hold && st.w_hold && !st.bvalid;
	assign do_read  = s_axi_arvalid_in && st.arready;

	// Timer advance source
	// RQ18: power-managed tick select
	assign tick = st.period_timer_run && (pm_clock_select_in ? pm_tick_in : 1'b1);
	assign period_begin = tick && (st.timer_count == st.period_register);

	// Outputs forced while any shutdown term holds
	// RQ9: period latch keeps shutdown
	assign hold_shutdown = st.shutdown_status || st.period_shutdown || cause_raw;

	// Register image of the shutdown control register
	// RQ6: B/D field reads zero
	assign reg_shutdown = {st.shutdown_status, st.shutdown_source_select,
		st.pair_ac_shutdown_state,
		REDUCED_PINS ? 2'b00 : st.pair_bd_shutdown_state};

	//------------------------------------------------------------
	// Per-pin shutdown and normal drive
	//------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			// Pins A and C use the A/C field, B and D the B/D field
			localparam bit IS_AC = (gi == 0) || (gi == 2);
			logic [1:0] sd_field;
			logic       pol_low;
			logic       unused_pin;
			// RQ3: A/C shutdown state
			// RQ4: B/D shutdown state
			assign sd_field   = IS_AC ? st.pair_ac_shutdown_state : st.pair_bd_shutdown_state;
			// RQ13: per-pair polarity
			assign pol_low    = IS_AC ? st.polarity_select[pwmas_pkg::BIT_POL_AC]
				: st.polarity_select[pwmas_pkg::BIT_POL_BD];
			// RQ5: single output only
			assign unused_pin = REDUCED_PINS && (gi != 0);
			// Bit 3 tri-state, bit 2 level when shut down, bits 1:0 normal
			assign pin_state[gi] = {sd_field[1] || unused_pin, sd_field[0],
				unused_pin, pwm_in[gi] ^ pol_low};
		end
	endgenerate

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	// Compute all next values; sleep freezes timer, status and pins, bus writes still land
	always_comb begin
		next_st = st;
		// Source synchronisers
		next_st.src_meta = src_raw;
		next_st.src_sync = st.src_meta;
		// Write address and data capture, in either order
		if (s_axi_awvalid_in && st.awready) begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && st.wready) begin
			next_st.w_hold  = 1'b1;
			next_st.w_data  = s_axi_wdata_in[7:0];
			next_st.w_lane0 = s_axi_wstrb_in[0];
		end
		if (st.bvalid && s_axi_bready_in) begin
			next_st.bvalid = 1'b0;
		end
		if (!sleep_in) begin
			// Period timer
			// RQ17: sleep freezes timer
			if (period_begin) begin
				next_st.timer_count = 8'h00;
			end else if (tick) begin
				next_st.timer_count = st.timer_count + 8'h01;
			end
			// Period latch takes the status at the period boundary
			// RQ20: whole period shut down
			if (period_begin) begin
				next_st.period_shutdown = st.shutdown_status;
			end
		end
		// Register write, lane 0 carries every implemented bit
		if (do_write) begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = pwmas_pkg::RESP_OKAY;
			case (st.aw_addr)
				pwmas_pkg::OFS_SHUTDOWN: begin
					if (st.w_lane0) begin
						next_st.shutdown_source_select = st.w_data[pwmas_pkg::BIT_SEL_LO +: 3];
						next_st.pair_ac_shutdown_state = st.w_data[pwmas_pkg::BIT_AC_LO +: 2];
						next_st.pair_bd_shutdown_state = REDUCED_PINS ? 2'b00
							: st.w_data[pwmas_pkg::BIT_BD_LO +: 2];
						// RQ10: write ignored on cause
						// RQ12: software forced shutdown
						if (!cause_sync && !sleep_in) begin
							next_st.shutdown_status = st.w_data[pwmas_pkg::BIT_STATUS];
						end
					end
				end
				pwmas_pkg::OFS_CONFIG: begin
					if (st.w_lane0) begin
						next_st.auto_restart_enable = st.w_data[pwmas_pkg::BIT_RESTART];
					end
				end
				pwmas_pkg::OFS_MODULE: begin
					if (st.w_lane0) begin
						next_st.polarity_select = st.w_data[1:0];
					end
				end
				pwmas_pkg::OFS_PERIOD: begin
					if (st.w_lane0) begin
						next_st.period_register = st.w_data;
					end
				end
				pwmas_pkg::OFS_TIMER: begin
					if (st.w_lane0) begin
						next_st.period_timer_run = st.w_data[pwmas_pkg::BIT_RUN];
						if (!st.w_data[pwmas_pkg::BIT_FLAG]) begin
							next_st.period_timer_flag = 1'b0;
						end
					end
				end
				default: begin
					next_st.bresp = pwmas_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (!sleep_in) begin
			// RQ7: auto restart clears status
			if (st.auto_restart_enable && !cause_sync
				&& !(do_write && st.aw_addr == pwmas_pkg::OFS_SHUTDOWN && st.w_lane0)) begin
				next_st.shutdown_status = 1'b0;
			end
			// RQ8: status held until software
			// RQ11: level cause keeps status
			if (cause_sync) begin
				next_st.shutdown_status = 1'b1;
			end
			// RQ9: set status extends period latch
			if (next_st.shutdown_status) begin
				next_st.period_shutdown = 1'b1;
			end
			// RQ15: flag at each period start
			if (period_begin) begin
				next_st.period_timer_flag = 1'b1;
			end
		end
		// Read channel
		if (st.rvalid && s_axi_rready_in) begin
			next_st.rvalid = 1'b0;
		end
		if (do_read) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = pwmas_pkg::RESP_OKAY;
			case (s_axi_araddr_in)
				pwmas_pkg::OFS_SHUTDOWN: next_st.rdata = reg_shutdown;
				pwmas_pkg::OFS_CONFIG:   next_st.rdata = {st.auto_restart_enable, 7'h00};
				pwmas_pkg::OFS_MODULE:   next_st.rdata = {6'h00, st.polarity_select};
				pwmas_pkg::OFS_PERIOD:   next_st.rdata = st.period_register;
				pwmas_pkg::OFS_TIMER:    next_st.rdata = {6'h00, st.period_timer_flag,
					st.period_timer_run};
				default: begin
					next_st.rdata = 8'h00;
					next_st.rresp = pwmas_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Ready signals registered from the next hold state
		next_st.awready = !next_st.aw_hold && !next_st.bvalid;
		next_st.wready  = !next_st.w_hold && !next_st.bvalid;
		next_st.arready = !next_st.rvalid && !do_read;
		// Pin drive; sleep keeps the last driven value
		if (!sleep_in) begin
			for (int i = 0; i < 4; i++) begin
				if (hold_shutdown) begin
					next_st.pins[i].oe_b  = pin_state[i][3];
					next_st.pins[i].level = pin_state[i][2];
				end else begin
					next_st.pins[i].oe_b  = pin_state[i][1];
					next_st.pins[i].level = pin_state[i][0];
				end
			end
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	// Synchronous active-low reset to all-quiet values
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st                  <= '0;
			st.period_register  <= pwmas_pkg::RST_PERIOD;
			{st.shutdown_status, st.shutdown_source_select, st.pair_ac_shutdown_state,
				st.pair_bd_shutdown_state} <= pwmas_pkg::RST_SHUTDOWN;
			st.pins             <= {4{2'b01}};
		end else begin
			st <= next_st;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	// All outputs come straight from state flip-flops
	assign s_axi_awready_out     = st.awready;
	assign s_axi_wready_out      = st.wready;
	assign s_axi_bvalid_out      = st.bvalid;
	assign s_axi_bresp_out       = st.bresp;
	assign s_axi_arready_out     = st.arready;
	assign s_axi_rvalid_out      = st.rvalid;
	assign s_axi_rdata_out       = {24'h00_0000, st.rdata};
	assign s_axi_rresp_out       = st.rresp;
	assign output_a_out          = st.pins[0];
	assign output_b_out          = st.pins[1];
	assign output_c_out          = st.pins[2];
	assign output_d_out          = st.pins[3];
	assign period_timer_flag_out = st.period_timer_flag;

endmodule // pwmas_core

/* core/pwmas_pkg.sv */
// Constants and carrier types for the PWM auto-shutdown and restart block
//------------------------------------------------------------
// Overview of operation
// RQ1: Bit 7 of shutdown control holds status; 1 means outputs are shut down.
// RQ2: Bits 6-4 select sources: none, comp1, comp2, either, pin, pin+comps.
// RQ3: During shutdown pins A and C tri-state on 1x, high on 01, low on 00.
// RQ4: During shutdown pins B and D tri-state on 1x, high on 01, low on 00.
// RQ5: Reduced pin variant tri-states its single output when the A/C field is 1x.
// RQ6: Reduced pin variant leaves the B/D field unimplemented, reading zero.
// RQ7: With auto restart, status stays set while cause lasts, then clears itself.
// RQ8: Without auto restart, status stays set until software clears it.
// RQ9: After status clears, outputs stay shut down until the next period begins.
// RQ10: Software writes to the status bit are ignored while a cause is active.
// RQ11: Comparator sources act as levels; status cannot clear while one persists.
// RQ12: Software writing 1 to the status bit forces shutdown.
// RQ13: Two low mode bits choose polarity per pair A/C and B/D.
// RQ14: Software sets polarity before enabling outputs; never change it while driving.
// RQ15: Run one full period before enabling outputs; timer flag marks period two.
// RQ16: Software follows the documented setup order before enabling outputs.
// RQ17: Sleep freezes the timer and all state; driven pins keep their values. Here bus writes other than the status bit still land in sleep.
// RQ18: Primary idle runs unchanged; other modes clock the timer from their tick.
// RQ19: A shutdown event forces the pins without waiting for a period boundary.
// RQ20: Status set at a period start keeps outputs shut down that whole period.
// RQ21: A low fault pin is a shutdown event when that pin is selected.
// RQ22: Sources are synchronised for status; the pin override acts at once.
//------------------------------------------------------------
package pwmas_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_SHUTDOWN = 5'h00;
	localparam logic [4:0] OFS_CONFIG   = 5'h04;
	localparam logic [4:0] OFS_MODULE   = 5'h08;
	localparam logic [4:0] OFS_PERIOD   = 5'h0C;
	localparam logic [4:0] OFS_TIMER    = 5'h10;

	// Field positions
	localparam int BIT_STATUS   = 7;
	localparam int BIT_SEL_LO   = 4;
	localparam int BIT_AC_LO    = 2;
	localparam int BIT_BD_LO    = 0;
	localparam int BIT_RESTART  = 7;
	localparam int BIT_POL_AC   = 1;
	localparam int BIT_POL_BD   = 0;
	localparam int BIT_RUN      = 0;
	localparam int BIT_FLAG     = 1;

	// Reset values
	localparam logic [7:0] RST_SHUTDOWN = 8'h00;
	localparam logic [7:0] RST_PERIOD   = 8'hFF;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Fault sources, all active high after the pin is inverted
	typedef struct packed {
		logic fault_pin;
		logic comp2;
		logic comp1;
	} pwmas_src_type;

	// One output pin: level and active-low output enable
	typedef struct packed {
		logic level;
		logic oe_b;
	} pwmas_pin_type;

endpackage // pwmas_pkg

/* testbench/pwmas_core_properties.sv */
// Bound checks on the shutdown core ports
`timescale 1ns/10ps
//------
// Checker
//------
module pwmas_chk (
	// Clock and reset
	input wire logic                     clk_in,
	input wire logic                     rst_b_in,
	// Register bus
	input wire logic                     s_axi_awvalid_in,
	input wire logic                     s_axi_awready_out,
	input wire logic [4:0]               s_axi_awaddr_in,
	input wire logic                     s_axi_wvalid_in,
	input wire logic                     s_axi_wready_out,
	input wire logic [31:0]              s_axi_wdata_in,
	input wire logic                     s_axi_bvalid_out,
	input wire logic                     s_axi_bready_in,
	input wire logic [1:0]               s_axi_bresp_out,
	input wire logic                     s_axi_arvalid_in,
	input wire logic                     s_axi_arready_out,
	input wire logic [4:0]               s_axi_araddr_in,
	input wire logic                     s_axi_rvalid_out,
	input wire logic [31:0]              s_axi_rdata_out,
	input wire logic [1:0]               s_axi_rresp_out,
	// Pins
	input wire logic                     fault_input_pin_b_in,
	input wire logic                     sleep_in,
	input wire pwmas_pkg::pwmas_pin_type output_a_out,
	input wire logic                     period_timer_flag_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [4:0] ar_q;
	logic [7:0] sd_q;
	// Shadows of the read address and the shutdown control value
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) sd_q <= 8'h00;
		else if (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
			&& s_axi_wready_out && s_axi_awaddr_in == 5'h00) sd_q <= s_axi_wdata_in[7:0];
		if (s_axi_arvalid_in && s_axi_arready_out) ar_q <= s_axi_araddr_in;
	end
	chk_read_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
		s_axi_rvalid_out) else $error("read answer late");
	chk_rdata_upper: assert property (s_axi_rvalid_out |->
		s_axi_rdata_out[31:8] == 24'h00_0000) else $error("upper read bits set");
	chk_unmapped_resp: assert property (s_axi_rvalid_out |->
		(s_axi_rresp_out == pwmas_pkg::RESP_SLVERR) == (ar_q > 5'h10)) else $error("bad rresp");
	chk_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
	chk_write_refuse: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out) else $error("write taken early");
	chk_reset_pins: assert property ($rose(rst_b_in) |->
		output_a_out.oe_b && !period_timer_flag_out) else $error("pin driven after reset");
	chk_flag_clear: assert property ($fell(period_timer_flag_out) |->
		$rose(s_axi_bvalid_out)) else $error("flag dropped without write");
	chk_sleep_freeze: assert property (sleep_in |=> $stable(output_a_out)
		&& $stable(period_timer_flag_out)) else $error("state moved in sleep");
	chk_pin_force: assert property (sd_q[6] && !fault_input_pin_b_in && !sleep_in
		&& s_axi_awready_out && !s_axi_awvalid_in && !s_axi_bvalid_out
		|=> output_a_out.oe_b == sd_q[3] && (sd_q[3] || output_a_out.level == sd_q[2]))
		else $error("pin not forced");
	cov_fault: cover property (sd_q[6] && !fault_input_pin_b_in);
	cov_sleep: cover property (sleep_in ##1 sleep_in);
	cov_flag: cover property ($rose(period_timer_flag_out));
endmodule // pwmas_chk
bind pwmas_core pwmas_chk pwmas_chk_i (.clk_in, .rst_b_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_bvalid_out,
	.s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
	.s_axi_rvalid_out, .s_axi_rdata_out, .s_axi_rresp_out, .fault_input_pin_b_in, .sleep_in,
	.output_a_out, .period_timer_flag_out);

/* testbench/pwmas_far_side.sv */
// Fault sources and modulator stand-in facing the shutdown core
`timescale 1ns/10ps
//------
// Far side
//------
module pwmas_far_side (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// Requested causes: bit 0 comp1, bit 1 comp2, bit 2 fault pin
	input  wire logic [2:0] cause_in,
	// Source and modulator levels
	output logic            fault_input_pin_b_out,
	output logic            comp1_out,
	output logic            comp2_out,
	output logic [3:0]      pwm_out
);
	// fault pin low
	// Pin sits at its pull-up level unless a fault is asked for
	assign fault_input_pin_b_out = !cause_in[2];
	// comparator levels
	// Comparators hold their level for as long as the cause lasts
	assign comp1_out = cause_in[0];
	assign comp2_out = cause_in[1];
	// Modulated pattern that changes every cycle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) pwm_out <= 4'h0;
		else pwm_out <= pwm_out + 4'h5;
	end
endmodule // pwmas_far_side

/* testbench/pwmas_core_bench.sv */
// Self-checking bench for the shutdown core
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, e); err_count++; end end
//------
// Bench
//------
module pwmas_core_bench;
	logic clk_in = 1'b0, rst_b_in = 1'b0, sleep_in = 1'b0, pm_clock_select_in = 1'b0;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, pm_tick_in = 1'b0;
	logic [4:0] s_axi_awaddr_in = 5'h00, s_axi_araddr_in = 5'h00;
	logic [31:0] s_axi_wdata_in = 32'h0000_0000, s_axi_rdata_out;
	logic [2:0] cause = 3'h0;
	logic tick_run = 1'b1;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, period_timer_flag_out, fault_input_pin_b_in, comp1_in, comp2_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [3:0] pwm_in;
	pwmas_pkg::pwmas_pin_type output_a_out, output_b_out, output_c_out, output_d_out;
	int err_count = 0, checks_done = 0;
	pwmas_core #(.REDUCED_PINS(1'b0)) pwmas_core_i (.clk_in, .rst_b_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in(4'hF), .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
		.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out,
		.s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out, .fault_input_pin_b_in, .comp1_in,
		.comp2_in, .sleep_in, .pm_clock_select_in, .pm_tick_in, .pwm_in, .output_a_out,
		.output_b_out, .output_c_out, .output_d_out, .period_timer_flag_out);
	pwmas_far_side pwmas_far_side_i (.clk_in, .rst_b_in, .cause_in(cause),
		.fault_input_pin_b_out(fault_input_pin_b_in), .comp1_out(comp1_in),
		.comp2_out(comp2_in), .pwm_out(pwm_in));
	// Clock and a managed-clock tick every second cycle
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) pm_tick_in <= tick_run && !pm_tick_in;
	// Bus write, waits for the answer
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] e = pwmas_pkg::RESP_OKAY);
		@(posedge clk_in);
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h00_0000, d};
		do begin
			@(posedge clk_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		`CHK(s_axi_bresp_out, e)
	endtask
	// Bus read compared with an expected word
	task automatic rd(input logic [4:0] a, input logic [31:0] x,
		input logic [1:0] e = pwmas_pkg::RESP_OKAY);
		@(posedge clk_in);
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
		s_axi_araddr_in <= a;
		do begin
			@(posedge clk_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		`CHK(s_axi_rdata_out, x)
		`CHK(s_axi_rresp_out, e)
	endtask
	// One pin against a state code
	task automatic pin1(input pwmas_pkg::pwmas_pin_type o, input logic [1:0] s);
		`CHK(o.oe_b, s[1])
		if (!s[1]) `CHK(o.level, s[0])
	endtask
	task automatic shut(input logic [1:0] ac, input logic [1:0] bd);
		pin1(output_a_out, ac);
		pin1(output_c_out, ac);
		pin1(output_b_out, bd);
		pin1(output_d_out, bd);
	endtask
	// Normal levels follow the modulator with the chosen polarity
	task automatic norm(input logic [1:0] pol);
		logic [3:0] p;
		@(posedge clk_in);
		p = pwm_in;
		#1;
		pin1(output_a_out, {1'b0, p[0] ^ pol[1]});
		pin1(output_b_out, {1'b0, p[1] ^ pol[0]});
		pin1(output_c_out, {1'b0, p[2] ^ pol[1]});
		pin1(output_d_out, {1'b0, p[3] ^ pol[0]});
	endtask
	task automatic wait_flag(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			if (period_timer_flag_out === 1'b1) break;
		end
		`CHK(period_timer_flag_out, 1'b1)
	endtask
	// Clear the flag and wait for the next period begin
	task automatic align(input int n = 80);
		wr(5'h10, 8'h01);
		wait_flag(n);
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#1000000;
		err_count++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		#1 shut(2'b11, 2'b11);
		rd(5'h00, 32'h0000_0000);
		rd(5'h0C, 32'h0000_00FF);
		rd(5'h14, 32'h0000_0000, pwmas_pkg::RESP_SLVERR);
		wr(5'h18, 8'hFF, pwmas_pkg::RESP_SLVERR);
		// Every source code against each single cause, restart off
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 3; k++) begin
				wr(5'h00, {1'b0, 3'(s), 4'h5});
				cause <= 3'b001 << k;
				repeat (6) @(posedge clk_in);
				wr(5'h00, {1'b0, 3'(s), 4'h5});
				rd(5'h00, {24'h00_0000, s[k], 3'(s), 4'h5});
				cause <= 3'b000;
				repeat (6) @(posedge clk_in);
				rd(5'h00, {24'h00_0000, s[k], 3'(s), 4'h5});
			end
		end
		// Timer started; each shutdown state from a clean period, pin cause only
		wr(5'h0C, 8'h3F);
		wr(5'h10, 8'h01);
		for (int t = 0; t < 4; t++) begin
			wr(5'h00, {4'b0100, 2'(t), 2'(3 - t)});
			align();
			cause <= 3'b100;
			repeat (2) @(posedge clk_in);
			#1 shut(2'(t), 2'(3 - t));
			cause <= 3'b000;
			repeat (6) @(posedge clk_in);
		end
		// Forced shutdown, polarity set while tri-stated, restart at boundary
		align();
		for (int p = 0; p < 4; p++) begin
			wr(5'h00, 8'hCA);
			#1 shut(2'b10, 2'b10);
			wr(5'h08, 8'(p));
			wr(5'h00, 8'h4A);
			#1 shut(2'b10, 2'b10);
			align();
			norm(2'(p));
		end
		// Automatic restart clears status once the cause has gone
		wr(5'h04, 8'h80);
		align();
		wr(5'h00, 8'h45);
		cause <= 3'b100;
		repeat (6) @(posedge clk_in);
		rd(5'h00, 32'h0000_00C5);
		cause <= 3'b000;
		repeat (6) @(posedge clk_in);
		rd(5'h00, 32'h0000_0045);
		#1 shut(2'b01, 2'b01);
		align();
		norm(2'b11);
		// Timer frozen in sleep and with a stopped managed clock
		for (int m = 0; m < 2; m++) begin
			align();
			wr(5'h10, 8'h01);
			{sleep_in, pm_clock_select_in} <= 2'b10 >> m;
			tick_run <= (m == 0);
			repeat (150) @(posedge clk_in);
			`CHK(period_timer_flag_out, 1'b0)
			{sleep_in, pm_clock_select_in} <= 2'b00;
			tick_run <= 1'b1;
		end
		// Managed clock at half rate is slower than one primary period
		pm_clock_select_in <= 1'b1;
		align(150);
		wr(5'h10, 8'h01);
		repeat (70) @(posedge clk_in);
		`CHK(period_timer_flag_out, 1'b0)
		wait_flag(200);
		summarize();
	end
endmodule // pwmas_core_bench
